// [gdc_defs.svh]
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define GDC_PIN_CFG_IDX     8'h21
`define GDC_DP_CTL_IDX      8'h22
`define GDC_STATUS_IDX      8'h30
`define GDC_ADDR_W          8

// ==========================================================
// reset values
`define GDC_PIN_CFG_RST     8'h00
`define GDC_DP_CTL_RST      8'h00

// ==========================================================
// pin7/pin8 configuration fields
`define GDC_P8_LEVEL_BIT    7
`define GDC_P8_FAR_BIT      6
`define GDC_P8_DIR_BIT      5
`define GDC_P8_EN_BIT       4
`define GDC_P7_LEVEL_BIT    3
`define GDC_P7_FAR_BIT      2
`define GDC_P7_DIR_BIT      1
`define GDC_P7_EN_BIT       0

// ==========================================================
// datapath control fields
`define GDC_HOLD_BIT        7
`define GDC_BYPASS_BIT      6
`define GDC_SENSE_BIT       5
`define GDC_REGEN_BIT       4
`define GDC_FOURCH_OVR_BIT  3
`define GDC_WIDTH18_BIT     2
`define GDC_INBAND_BIT      1
`define GDC_FOURCH_EN_BIT   0
`define GDC_FC_LOAD_MASK    8'h7f

// ==========================================================
// status fields
`define GDC_ST_P7_IN_BIT    0
`define GDC_ST_P8_IN_BIT    1
`define GDC_ST_P7_OE_BIT    2
`define GDC_ST_P8_OE_BIT    3
`define GDC_ST_FOURCH_BIT   4

// ==========================================================
// bus answers and pixel width
`define GDC_RESP_OKAY       2'h0
`define GDC_RESP_SLVERR     2'h2
`define GDC_PIX_W           24

`endif

// [gdc_pkg.sv]
`include "gdc_defs.svh"

package gdc_pkg;

    typedef enum logic [1:0] {
        GDC_PAD_FUNC_OUT = 2'b00,
        GDC_PAD_GPIO_OUT = 2'b01,
        GDC_PAD_HIZ      = 2'b10,
        GDC_PAD_GPIO_IN  = 2'b11
    } gdc_pad_mode_t;

    typedef enum logic [1:0] {
        GDC_SEL_PIN_CFG = 2'b00,
        GDC_SEL_DP_CTL  = 2'b01,
        GDC_SEL_STATUS  = 2'b10,
        GDC_SEL_NONE    = 2'b11
    } gdc_sel_t;

    typedef struct packed {
        logic [2:0] sync;
        logic       in_level;
        logic       out;
        logic       oe;
    } gdc_pad_state_t;

    typedef struct packed {
        logic                   aw_rdy;
        logic                   w_rdy;
        logic [`GDC_ADDR_W-1:0] aw_addr;
        logic [7:0]             w_data;
        logic                   w_lane0;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   ar_rdy;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [7:0]             pin_cfg;
        logic [7:0]             dp_ctl;
        logic [`GDC_PIX_W-1:0]  pix_data;
        logic                   pix_valid;
        logic                   cp_enable;
        logic                   audio_pkt;
        logic                   audio_on_pix;
        logic                   four_ch;
        logic                   width18;
        logic                   inband;
    } gdc_state_t;

endpackage

// [gdc_pad_if.sv]
interface gdc_pad_if;
    import gdc_pkg::*;

    logic far_control;
    logic direction;
    logic function_on;
    logic local_level;
    logic far_level;
    logic func_level;
    logic in_level;
    logic out;
    logic oe;

    modport ctl (
        output far_control,
        output direction,
        output function_on,
        output local_level,
        output far_level,
        output func_level,
        input  in_level,
        input  out,
        input  oe
    );

    modport pad (
        input  far_control,
        input  direction,
        input  function_on,
        input  local_level,
        input  far_level,
        input  func_level,
        output in_level,
        output out,
        output oe
    );
endinterface

// [gdc_pad.sv]
module gdc_pad
    import gdc_pkg::*;
(
    input  wire logic mclk,    // core clock
    input  wire logic rst_b,   // async reset
    input  wire logic pin_i,   // pad input level
    gdc_pad_if.pad    pif      // configuration and pad drive
);

    gdc_pad_state_t s_r;
    gdc_pad_state_t s_nxt;
    gdc_pad_mode_t  mode;

    assign mode = gdc_pad_mode_t'({pif.direction, pif.function_on});

    always_comb begin
        s_nxt = s_r;
        // pad input crosses in; first stage feeds only the second
        s_nxt.sync = {s_r.sync[1:0], pin_i};
        if (s_r.sync[1] == s_r.sync[2]) begin
            s_nxt.in_level = s_r.sync[2];
        end
        if (pif.far_control) begin
            s_nxt.oe  = 1'b1;
            s_nxt.out = pif.far_level;
        end else begin
            unique case (mode)
                GDC_PAD_FUNC_OUT: begin
                    s_nxt.oe  = 1'b1;
                    s_nxt.out = pif.func_level;
                end
                GDC_PAD_GPIO_OUT: begin
                    s_nxt.oe  = 1'b1;
                    s_nxt.out = pif.local_level;
                end
                GDC_PAD_HIZ: begin
                    s_nxt.oe  = 1'b0;
                    s_nxt.out = 1'b0;
                end
                GDC_PAD_GPIO_IN: begin
                    s_nxt.oe  = 1'b0;
                    s_nxt.out = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pif.in_level = s_r.in_level;
    assign pif.out      = s_r.out;
    assign pif.oe       = s_r.oe;

endmodule

// [gdc_regs.sv]
// Contract
// - local level drives pin only if function on, output direction, far control off.
// - far control set forces pin output with level received from far end.
// - direction/enable pair: 00 functional, 10 hi-z, 01 gpio out, 11 gpio in.
// - hold bit set blocks forward-channel loading, keeps locally written values.
// - forward-channel configuration updates datapath lower bits unless hold set.
// - bypass set forwards pixel data regardless of pixel valid.
// - bypass disables content protection and blocks packetized audio.
// - sense bit 1 means valid active low; 0 means active high.
// - regen bit set suppresses packetized audio on pixel pins.
// - four-channel override set follows bit 0; clear forces four-channel off.
// - width bit 1 selects 18-bit video, 0 selects 24-bit.
// - transport bit 1 selects in-band audio, 0 data-island.
// - four-channel enable bit turns four-channel audio on or off.
// - datapath control resets to zero, all bits read/write.
module gdc_regs
    import gdc_pkg::*;
(
    input  wire logic                  mclk,             // core clock, 250 MHz
    input  wire logic                  rst_b,            // async reset
    // axi4-lite slave
    input  wire logic [`GDC_ADDR_W+1:0] s_axi_awaddr,    // write address
    input  wire logic                  s_axi_awvalid,    // write address valid
    output logic                       s_axi_awready,    // write address ready
    input  wire logic [31:0]           s_axi_wdata,      // write data
    input  wire logic [3:0]            s_axi_wstrb,      // byte enables
    input  wire logic                  s_axi_wvalid,     // write data valid
    output logic                       s_axi_wready,     // write data ready
    output logic [1:0]                 s_axi_bresp,      // write response
    output logic                       s_axi_bvalid,     // write response valid
    input  wire logic                  s_axi_bready,     // write response ready
    input  wire logic [`GDC_ADDR_W+1:0] s_axi_araddr,    // read address
    input  wire logic                  s_axi_arvalid,    // read address valid
    output logic                       s_axi_arready,    // read address ready
    output logic [31:0]                s_axi_rdata,      // read data
    output logic [1:0]                 s_axi_rresp,      // read response
    output logic                       s_axi_rvalid,     // read data valid
    input  wire logic                  s_axi_rready,     // read data ready
    // forward channel
    input  wire logic                  fc_cfg_valid,     // datapath config strobe
    input  wire logic [6:0]            fc_cfg_data,      // datapath config bits
    input  wire logic [1:0]            far_level,        // far levels, pin8/pin7
    // pins
    input  wire logic [1:0]            func_level,       // functional levels
    input  wire logic                  pin7_i,           // pin7 input
    output logic                       pin7_o,           // pin7 drive level
    output logic                       pin7_oe,          // pin7 drive enable
    input  wire logic                  pin8_i,           // pin8 input
    output logic                       pin8_o,           // pin8 drive level
    output logic                       pin8_oe,          // pin8 drive enable
    // pixel path
    input  wire logic [`GDC_PIX_W-1:0] pix_data_i,       // pixel data in
    input  wire logic                  pixel_valid,      // raw data enable
    input  wire logic                  cp_request,       // protection requested
    input  wire logic                  audio_pkt_i,      // packetized audio in
    output logic [`GDC_PIX_W-1:0]      pix_data_o,       // pixel data out
    output logic                       pix_valid_o,      // pixel valid out
    output logic                       cp_enable,        // protection active
    output logic                       audio_pkt_o,      // packetized audio out
    output logic                       audio_on_pix,     // audio on pixel pins
    output logic                       four_ch_on,       // four-channel audio
    output logic                       video_18bit,      // 18-bit mode
    output logic                       audio_inband      // in-band transport
);

    // ======================================================
    // address decode

    function automatic gdc_sel_t decode(input logic [`GDC_ADDR_W+1:0] addr);
        logic [`GDC_ADDR_W-1:0] idx;
        idx = addr[`GDC_ADDR_W+1:2];
        if (idx == `GDC_PIN_CFG_IDX) begin
            decode = GDC_SEL_PIN_CFG;
        end else if (idx == `GDC_DP_CTL_IDX) begin
            decode = GDC_SEL_DP_CTL;
        end else if (idx == `GDC_STATUS_IDX) begin
            decode = GDC_SEL_STATUS;
        end else begin
            decode = GDC_SEL_NONE;
        end
    endfunction

    // ======================================================
    // pads

    gdc_pad_if p7_if ();
    gdc_pad_if p8_if ();

    gdc_state_t s_r;
    gdc_state_t s_nxt;
    gdc_sel_t   wsel;
    gdc_sel_t   rsel;
    logic [7:0] status;
    logic       fc_load;
    logic       sensed_valid;

    assign p7_if.far_control = s_r.pin_cfg[`GDC_P7_FAR_BIT];
    assign p7_if.direction   = s_r.pin_cfg[`GDC_P7_DIR_BIT];
    assign p7_if.function_on = s_r.pin_cfg[`GDC_P7_EN_BIT];
    assign p7_if.local_level = s_r.pin_cfg[`GDC_P7_LEVEL_BIT];
    assign p7_if.far_level   = far_level[0];
    assign p7_if.func_level  = func_level[0];
    assign p8_if.far_control = s_r.pin_cfg[`GDC_P8_FAR_BIT];
    assign p8_if.direction   = s_r.pin_cfg[`GDC_P8_DIR_BIT];
    assign p8_if.function_on = s_r.pin_cfg[`GDC_P8_EN_BIT];
    assign p8_if.local_level = s_r.pin_cfg[`GDC_P8_LEVEL_BIT];
    assign p8_if.far_level   = far_level[1];
    assign p8_if.func_level  = func_level[1];

    gdc_pad u_pin7 (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin_i (pin7_i),
        .pif   (p7_if.pad)
    );

    gdc_pad u_pin8 (
        .mclk  (mclk),
        .rst_b (rst_b),
        .pin_i (pin8_i),
        .pif   (p8_if.pad)
    );

    // ======================================================
    // next state

    assign wsel = decode({s_r.aw_addr, 2'b00});
    assign rsel = decode(s_axi_araddr);

    always_comb begin
        status = 8'h00;
        status[`GDC_ST_P7_IN_BIT]  = p7_if.in_level;
        status[`GDC_ST_P8_IN_BIT]  = p8_if.in_level;
        status[`GDC_ST_P7_OE_BIT]  = p7_if.oe;
        status[`GDC_ST_P8_OE_BIT]  = p8_if.oe;
        status[`GDC_ST_FOURCH_BIT] = s_r.four_ch;
    end

    assign fc_load = fc_cfg_valid & ~s_r.dp_ctl[`GDC_HOLD_BIT];
    assign sensed_valid = pixel_valid ^ s_r.dp_ctl[`GDC_SENSE_BIT];

    always_comb begin
        s_nxt = s_r;
        // address and data taken in either order, held until answered
        if (s_r.aw_rdy && s_axi_awvalid) begin
            s_nxt.aw_rdy  = 1'b0;
            s_nxt.aw_addr = s_axi_awaddr[`GDC_ADDR_W+1:2];
        end
        if (s_r.w_rdy && s_axi_wvalid) begin
            s_nxt.w_rdy   = 1'b0;
            s_nxt.w_data  = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        if (fc_load) begin
            s_nxt.dp_ctl = (s_r.dp_ctl & ~`GDC_FC_LOAD_MASK)
                         | ({1'b0, fc_cfg_data} & `GDC_FC_LOAD_MASK);
        end
        // software write lands after far load so it wins a same-cycle clash
        if (!s_r.aw_rdy && !s_r.w_rdy && !s_r.bvalid) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = `GDC_RESP_OKAY;
            unique case (wsel)
                GDC_SEL_PIN_CFG: begin
                    if (s_r.w_lane0) begin
                        s_nxt.pin_cfg = s_r.w_data;
                    end
                end
                GDC_SEL_DP_CTL: begin
                    if (s_r.w_lane0) begin
                        s_nxt.dp_ctl = s_r.w_data;
                    end
                end
                GDC_SEL_STATUS: begin
                    s_nxt.bresp = `GDC_RESP_OKAY;
                end
                GDC_SEL_NONE: begin
                    s_nxt.bresp = `GDC_RESP_SLVERR;
                end
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
            s_nxt.aw_rdy = 1'b1;
            s_nxt.w_rdy  = 1'b1;
        end
        // read answers one cycle after the address is taken
        if (s_r.ar_rdy && s_axi_arvalid) begin
            s_nxt.ar_rdy = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = `GDC_RESP_OKAY;
            unique case (rsel)
                GDC_SEL_PIN_CFG: s_nxt.rdata = {24'h000000, s_r.pin_cfg};
                GDC_SEL_DP_CTL:  s_nxt.rdata = {24'h000000, s_r.dp_ctl};
                GDC_SEL_STATUS:  s_nxt.rdata = {24'h000000, status};
                GDC_SEL_NONE: begin
                    s_nxt.rdata = 32'h00000000;
                    s_nxt.rresp = `GDC_RESP_SLVERR;
                end
            endcase
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.ar_rdy = 1'b1;
        end
        if (s_r.dp_ctl[`GDC_BYPASS_BIT] || sensed_valid) begin
            s_nxt.pix_valid = 1'b1;
            s_nxt.pix_data  = pix_data_i;
        end else begin
            s_nxt.pix_valid = 1'b0;
            s_nxt.pix_data  = '0;
        end
        // bypass kills protection and audio packets
        s_nxt.cp_enable = cp_request & ~s_r.dp_ctl[`GDC_BYPASS_BIT];
        s_nxt.audio_pkt = audio_pkt_i & ~s_r.dp_ctl[`GDC_BYPASS_BIT];
        // regen suppresses audio on pixel pins
        s_nxt.audio_on_pix = ~s_r.dp_ctl[`GDC_REGEN_BIT] & ~s_r.dp_ctl[`GDC_BYPASS_BIT];
        s_nxt.four_ch = s_r.dp_ctl[`GDC_FOURCH_OVR_BIT] & s_r.dp_ctl[`GDC_FOURCH_EN_BIT];
        s_nxt.width18 = s_r.dp_ctl[`GDC_WIDTH18_BIT];
        s_nxt.inband = s_r.dp_ctl[`GDC_INBAND_BIT];
    end

    // ======================================================
    // state register

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r         <= '0;
            s_r.aw_rdy  <= 1'b1;
            s_r.w_rdy   <= 1'b1;
            s_r.ar_rdy  <= 1'b1;
            s_r.pin_cfg <= `GDC_PIN_CFG_RST;
            s_r.dp_ctl  <= `GDC_DP_CTL_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ======================================================
    // outputs, all from flops

    assign s_axi_awready = s_r.aw_rdy;
    assign s_axi_wready  = s_r.w_rdy;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_arready = s_r.ar_rdy;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign pin7_o        = p7_if.out;
    assign pin7_oe       = p7_if.oe;
    assign pin8_o        = p8_if.out;
    assign pin8_oe       = p8_if.oe;
    assign pix_data_o    = s_r.pix_data;
    assign pix_valid_o   = s_r.pix_valid;
    assign cp_enable     = s_r.cp_enable;
    assign audio_pkt_o   = s_r.audio_pkt;
    assign audio_on_pix  = s_r.audio_on_pix;
    assign four_ch_on    = s_r.four_ch;
    assign video_18bit   = s_r.width18;
    assign audio_inband  = s_r.inband;

endmodule

// [gdc_regs_checker.sv]
`include "gdc_defs.svh"

module gdc_regs_checker (
    input wire logic                   mclk,          // clock
    input wire logic                   rst_b,         // reset
    input wire logic                   s_axi_awvalid, // aw valid
    input wire logic                   s_axi_awready, // aw ready
    input wire logic                   s_axi_wvalid,  // w valid
    input wire logic                   s_axi_wready,  // w ready
    input wire logic [1:0]             s_axi_bresp,   // b resp
    input wire logic                   s_axi_bvalid,  // b valid
    input wire logic                   s_axi_bready,  // b ready
    input wire logic [`GDC_ADDR_W+1:0] s_axi_araddr,  // ar addr
    input wire logic                   s_axi_arvalid, // ar valid
    input wire logic                   s_axi_arready, // ar ready
    input wire logic [31:0]            s_axi_rdata,   // r data
    input wire logic [1:0]             s_axi_rresp,   // r resp
    input wire logic                   s_axi_rvalid,  // r valid
    input wire logic                   s_axi_rready,  // r ready
    input wire logic [`GDC_PIX_W-1:0]  pix_data_i,    // pixel in
    input wire logic                   cp_request,    // protection req
    input wire logic                   audio_pkt_i,   // audio in
    input wire logic [`GDC_PIX_W-1:0]  pix_data_o,    // pixel out
    input wire logic                   pix_valid_o,   // valid out
    input wire logic                   cp_enable,     // protection out
    input wire logic                   audio_pkt_o,   // audio out
    input wire logic                   audio_on_pix   // audio on pixels
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // register bus
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr[9:2] inside
            {`GDC_PIN_CFG_IDX, `GDC_DP_CTL_IDX, `GDC_STATUS_IDX})
        |=> s_axi_rresp == `GDC_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_rd_width;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read data too wide");

    // ==========================================================
    // pixel path
    property p_pix_gate;
        !pix_valid_o |-> pix_data_o == '0;
    endproperty
    a_pix_gate: assert property (p_pix_gate) else $error("pixel data leaks");
    property p_pix_pass;
        pix_valid_o |-> pix_data_o == $past(pix_data_i);
    endproperty
    a_pix_pass: assert property (p_pix_pass) else $error("pixel data wrong");
    property p_cp_gate;
        cp_enable |-> $past(cp_request);
    endproperty
    a_cp_gate: assert property (p_cp_gate) else $error("protection unrequested");
    property p_audio_gate;
        audio_pkt_o |-> $past(audio_pkt_i);
    endproperty
    a_audio_gate: assert property (p_audio_gate) else $error("audio unrequested");
    // audio on pixels implies bypass off, so protection follows request
    property p_cp_follow;
        audio_on_pix |-> cp_enable == $past(cp_request);
    endproperty
    a_cp_follow: assert property (p_cp_follow) else $error("protection blocked");

    c_wr: cover property (s_axi_bvalid && s_axi_bready);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == `GDC_RESP_SLVERR);
    c_bypass: cover property (pix_valid_o && !cp_enable && $past(cp_request));
endmodule

bind gdc_regs gdc_regs_checker CHK (
    .mclk(mclk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pix_data_i(pix_data_i), .cp_request(cp_request),
    .audio_pkt_i(audio_pkt_i), .pix_data_o(pix_data_o), .pix_valid_o(pix_valid_o),
    .cp_enable(cp_enable), .audio_pkt_o(audio_pkt_o), .audio_on_pix(audio_on_pix)
);

// [gdc_far_model.sv]
module gdc_far_model (
    input  wire logic       mclk,         // clock
    output logic            fc_cfg_valid, // config strobe
    output logic [6:0]      fc_cfg_data,  // config bits
    output logic [1:0]      far_level     // far pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fc_cfg_valid = 1'b0;
        fc_cfg_data  = 7'h00;
        far_level    = 2'b10;
    end
    // one-cycle config frame; data not held once strobe drops
    task send(input logic [6:0] d);
        @(posedge mclk);
        fc_cfg_valid <= 1'b1;
        fc_cfg_data  <= d;
        @(posedge mclk);
        fc_cfg_valid <= 1'b0;
        fc_cfg_data  <= ~d;
    endtask
endmodule

// [gdc_regs_test.sv]
`include "gdc_defs.svh"

module gdc_regs_test;
    import gdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] A_PIN = {`GDC_PIN_CFG_IDX, 2'b00};
    localparam logic [9:0] A_DP  = {`GDC_DP_CTL_IDX, 2'b00};
    localparam logic [9:0] A_ST  = {`GDC_STATUS_IDX, 2'b00};
    localparam logic [9:0] A_BAD = 10'h100;
    localparam logic [1:0] OK    = `GDC_RESP_OKAY;
    localparam logic [1:0] ERR   = `GDC_RESP_SLVERR;

    logic                  mclk, rst_b;
    logic [9:0]            s_axi_awaddr, s_axi_araddr;
    logic [31:0]           s_axi_wdata, s_axi_rdata;
    logic [3:0]            s_axi_wstrb;
    logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                  s_axi_rvalid, s_axi_rready;
    logic [1:0]            s_axi_bresp, s_axi_rresp, far_level, func_level;
    logic                  fc_cfg_valid, pin7_o, pin7_oe, pin8_o, pin8_oe;
    logic [6:0]            fc_cfg_data;
    logic [`GDC_PIX_W-1:0] pix_data_i, pix_data_o;
    logic                  pixel_valid, cp_request, audio_pkt_i, pix_valid_o;
    logic                  cp_enable, audio_pkt_o, audio_on_pix, four_ch_on;
    logic                  video_18bit, audio_inband;
    wire                   pin7_i, pin8_i;
    int                    n_errors, n_checks;

    // undriven pads rest high on their pull-ups
    assign pin7_i = pin7_oe ? pin7_o : 1'b1;
    assign pin8_i = pin8_oe ? pin8_o : 1'b1;

    gdc_far_model FAR (.mclk(mclk), .fc_cfg_valid(fc_cfg_valid),
        .fc_cfg_data(fc_cfg_data), .far_level(far_level));

    gdc_regs DUT (.*);

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ==========================================================
    // helpers
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task rd(input logic [9:0] a, input logic [7:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        chk("rdata", {24'h0, e}, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
    endtask

    // ==========================================================
    // scenarios
    task t_reset;
        chk("pads after reset", 4'b1011, {pin8_oe, pin8_o, pin7_oe, pin7_o});
        rd(A_PIN, 8'h00, OK);
        rd(A_DP, 8'h00, OK);
    endtask

    task t_rw;
        wr(A_PIN, 8'ha5, OK);
        rd(A_PIN, 8'ha5, OK);
        wr(A_DP, 8'hff, OK);
        rd(A_DP, 8'hff, OK);
        wr(A_BAD, 8'h5a, ERR);
        rd(A_BAD, 8'h00, ERR);
    endtask

    task t_pins;
        logic [3:0] nib;
        logic       oe7, oe8;
        for (int i = 0; i < 8; i++) begin
            nib = {1'b1, i[2:0]};
            wr(A_PIN, {nib, nib}, OK);
            repeat (3) @(posedge mclk);
            oe7 = nib[2] | !nib[1];
            oe8 = oe7;
            chk("pin drive", {oe8, oe8 & (nib[2] | nib[0]), oe7, oe7 & !nib[2]},
                {pin8_oe, pin8_oe & pin8_o, pin7_oe, pin7_oe & pin7_o});
            if (i == 3) begin
                repeat (8) @(posedge mclk);
                rd(A_ST, 8'h13, OK);
            end
        end
    endtask

    task t_fc;
        wr(A_DP, 8'h00, OK);
        FAR.send(7'h0f);
        repeat (3) @(posedge mclk);
        rd(A_DP, 8'h0f, OK);
        chk("audio mode", 3'b111, {four_ch_on, video_18bit, audio_inband});
        FAR.send(7'h05);
        repeat (3) @(posedge mclk);
        rd(A_DP, 8'h05, OK);
        chk("audio mode", 3'b010, {four_ch_on, video_18bit, audio_inband});
        wr(A_DP, 8'h80, OK);
        FAR.send(7'h7f);
        rd(A_DP, 8'h80, OK);
    endtask

    task t_pix;
        logic [7:0] ctl [5] = '{8'h80, 8'ha0, 8'ha0, 8'hc0, 8'h90};
        logic [4:0] ex  [5] = '{5'b11111, 5'b00111, 5'b11111, 5'b11000, 5'b11110};
        logic [4:0] pv      = 5'b10011;
        cp_request  <= 1'b1;
        audio_pkt_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            wr(A_DP, ctl[i], OK);
            pixel_valid <= pv[i];
            repeat (3) @(posedge mclk);
            chk("pixel outputs", ex[i], {pix_valid_o, pix_data_o === pix_data_i,
                cp_enable, audio_pkt_o, audio_on_pix});
        end
    endtask

    task stop_test;
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        func_level  = 2'b01;
        pix_data_i  = 24'h5a3c71;
        {pixel_valid, cp_request, audio_pkt_i} = '0;
        n_errors = 0;
        n_checks = 0;
        rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        t_reset();
        t_rw();
        t_pins();
        t_fc();
        t_pix();
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge mclk);
        n_errors++;
        stop_test();
    end
endmodule
